// *** core/gies_top.sv ***
`timescale 1ns/1ps
module gies_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [3:0] regByteEn,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regAck,
  input wire logic vertical_blank,
  input wire logic vertical_line,
  input wire logic vertical_sync,
  input wire logic capture_snap,
  input wire logic dma_end_of_list,
  input wire logic two_wire_bus,
  input wire logic multimedia_port,
  input wire logic engine_idle,
  input wire logic host_video_port,
  input wire logic capture_port_zero_pending,
  input wire logic capture_port_one_pending,
  input wire logic intDisableStrap,
  output logic sysIrq
);
  localparam int N = gies_pkg::NUM_SRC;

  logic [N-1:0] srcRaw;
  logic [N-1:0] srcRise;
  logic [1:0] capLevel;
  logic strapLevel;

  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] stat_q, stat_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic irq_q, irq_d;

  logic [31:0] evSet;
  logic [31:0] clrMask;
  logic [31:0] laneMask;
  logic wrCtrl, wrStat;

  // byte enables widened to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lanes

  assign srcRaw = {host_video_port, engine_idle, multimedia_port,
                   two_wire_bus, dma_end_of_list, capture_snap,
                   vertical_sync, vertical_line, vertical_blank};

  gies_edge_sync #(.WIDTH(N)) uSrc (
    .mclk(mclk),
    .rst(rst),
    .async(srcRaw),
    .level(),
    .rise(srcRise)
  );

  gies_edge_sync #(.WIDTH(3)) uLvl (
    .mclk(mclk),
    .rst(rst),
    .async({intDisableStrap, capture_port_one_pending,
            capture_port_zero_pending}),
    .level({strapLevel, capLevel}),
    .rise()
  );

  // event onsets mapped to their flag positions
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : gMap
      if (g == gies_pkg::SRC_POS[0]) begin : gS0
        assign evSet[g] = srcRise[0];
      end else if (g == gies_pkg::SRC_POS[1]) begin : gS1
        assign evSet[g] = srcRise[1];
      end else if (g == gies_pkg::SRC_POS[2]) begin : gS2
        assign evSet[g] = srcRise[2];
      end else if (g == gies_pkg::SRC_POS[3]) begin : gS3
        assign evSet[g] = srcRise[3];
      end else if (g == gies_pkg::SRC_POS[4]) begin : gS4
        assign evSet[g] = srcRise[4];
      end else if (g == gies_pkg::SRC_POS[5]) begin : gS5
        assign evSet[g] = srcRise[5];
      end else if (g == gies_pkg::SRC_POS[6]) begin : gS6
        assign evSet[g] = srcRise[6];
      end else if (g == gies_pkg::SRC_POS[7]) begin : gS7
        assign evSet[g] = srcRise[7];
      end else if (g == gies_pkg::SRC_POS[8]) begin : gS8
        assign evSet[g] = srcRise[8];
      end else begin : gNone
        assign evSet[g] = 1'b0;
      end
    end
  endgenerate

  assign laneMask = lanes(regByteEn);
  assign wrStat = regSel && regWr && (regAddr == gies_pkg::STAT_OFFSET);
  // control takes only a full word write
  assign wrCtrl = regSel && regWr && (regAddr == gies_pkg::CTRL_OFFSET)
                  && (regByteEn == 4'hf);
  assign clrMask = wrStat ? (regWdata & laneMask) : 32'h00000000;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d = regWdata & gies_pkg::EVENT_MASK;
    end
    // set wins over clear; only event positions ever hold state
    stat_d = ((stat_q & ~clrMask) | evSet) & gies_pkg::EVENT_MASK;
    irq_d = ((stat_q & ctrl_q) != 32'h00000000) && !strapLevel;
    ack_d = regSel;
    rdata_d = 32'h00000000;
    if (regSel && !regWr) begin
      unique case (regAddr)
        gies_pkg::CTRL_OFFSET: rdata_d = ctrl_q;
        gies_pkg::STAT_OFFSET: begin
          rdata_d = stat_q;
          rdata_d[gies_pkg::CAP0_BIT] = capLevel[0];
          rdata_d[gies_pkg::CAP1_BIT] = capLevel[1];
          rdata_d = rdata_d & laneMask;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= gies_pkg::CTRL_RESET;
      stat_q <= gies_pkg::STAT_RESET;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      irq_q <= irq_d;
    end
  end

  assign regRdata = rdata_q;
  assign regAck = ack_q;
  assign sysIrq = irq_q;
endmodule : gies_top

// *** core/gies_pkg.sv ***
package gies_pkg;
  localparam logic [7:0] CTRL_OFFSET = 8'h40;
  localparam logic [7:0] STAT_OFFSET = 8'h44;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] STAT_RESET = 32'h00000000;
  localparam logic [31:0] EVENT_MASK = 32'h010f000f;
  localparam int VBLANK_BIT = 0;
  localparam int VLINE_BIT = 1;
  localparam int VSYNC_BIT = 2;
  localparam int SNAP_BIT = 3;
  localparam int CAP0_BIT = 8;
  localparam int CAP1_BIT = 9;
  localparam int DMA_EOL_BIT = 16;
  localparam int TWO_WIRE_BIT = 17;
  localparam int MM_PORT_BIT = 18;
  localparam int ENG_IDLE_BIT = 19;
  localparam int HVP_BIT = 24;
  localparam int NUM_SRC = 9;
  localparam int SRC_POS [NUM_SRC] = '{0, 1, 2, 3, 16, 17, 18, 19, 24};
endpackage : gies_pkg

// *** core/gies_edge_sync.sv ***
`timescale 1ns/1ps
module gies_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_q, meta_d;
  logic [WIDTH-1:0] sync_q, sync_d;
  logic [WIDTH-1:0] prev_q, prev_d;

  // refuse a width the flops cannot serve
  if (WIDTH < 1) begin : gBadWidth
    $error("gies_edge_sync: WIDTH must be at least 1");
  end

  // two flops before any reader, then an edge detector on the second
  always_comb begin
    meta_d = async;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
endmodule : gies_edge_sync

// *** verif/gies_sva.sv ***
`timescale 1ns/1ps
module gies_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regRdata,
  input wire logic regAck,
  input wire logic intDisableStrap,
  input wire logic sysIrq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic rd = regSel && !regWr;
  a_ack_next: assert property (regSel |=> regAck)
    else $error("no ack");
  a_ack_only: assert property (!regSel |=> !regAck)
    else $error("stray ack");
  a_idle_zero: assert property (!regAck |-> regRdata == '0)
    else $error("idle data");
  a_ctrl_rsvd: assert property (rd && regAddr == 8'h40
    |=> (regRdata & 32'hfef0fff0) == '0) else $error("ctrl rsvd");
  a_stat_rsvd: assert property (rd && regAddr == 8'h44
    |=> (regRdata & 32'hfef0fcf0) == '0) else $error("stat rsvd");
  a_unmapped_zero: assert property (rd && regAddr[7:4] != 4'h4
    |=> regRdata == '0) else $error("unmapped");
  a_strap_quiet: assert property (intDisableStrap [*5] |-> !sysIrq)
    else $error("irq strapped");
  a_irq_reset: assert property ($fell(rst) |-> !sysIrq)
    else $error("irq at reset");
endmodule : gies_sva

// *** verif/gies_host.sv ***
`timescale 1ns/1ps
module gies_host (
  input wire logic mclk,
  output logic regSel,
  output logic regWr,
  output logic [7:0] regAddr,
  output logic [3:0] regByteEn,
  output logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic regAck
);
  initial {regSel, regWr, regAddr, regByteEn, regWdata} = '0;
  // one access per select cycle, answer taken with its ack
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    {regSel, regWr, regAddr, regByteEn, regWdata} <= {1'b1, w, a, b, d};
    @(posedge mclk);
    regSel <= 1'b0;
    @(negedge mclk);
    q = regAck ? regRdata : 32'hdeadbeef;
  endtask : xfer
endmodule : gies_host

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench;
  logic mclk, rst, strap, cap0, cap1, irq, sel, wr, ack;
  logic [8:0] ev;
  logic [7:0] a;
  logic [3:0] be;
  logic [31:0] wd, rd, q;
  int failures = 0;
  int n_tests = 0;
  // rows: enable set on even sources, irq expected likewise
  localparam logic [8:0] EN_ROW = 9'h155;
  gies_host host (.mclk(mclk), .regSel(sel), .regWr(wr), .regAddr(a),
    .regByteEn(be), .regWdata(wd), .regRdata(rd), .regAck(ack));
  gies_top DUT (.mclk(mclk), .rst(rst), .regSel(sel), .regWr(wr),
    .regAddr(a), .regByteEn(be), .regWdata(wd), .regRdata(rd),
    .regAck(ack), .vertical_blank(ev[0]), .vertical_line(ev[1]),
    .vertical_sync(ev[2]), .capture_snap(ev[3]), .dma_end_of_list(ev[4]),
    .two_wire_bus(ev[5]), .multimedia_port(ev[6]), .engine_idle(ev[7]),
    .host_video_port(ev[8]), .capture_port_zero_pending(cap0),
    .capture_port_one_pending(cap1), .intDisableStrap(strap), .sysIrq(irq));
  task automatic rw(input logic w, input logic [7:0] ad, input logic [31:0] d);
    host.xfer(w, ad, 4'hf, d, q);
  endtask : rw
  task automatic pulse(input int i);
    @(posedge mclk) ev[i] <= 1'b1;
    repeat (4) @(posedge mclk);
    ev[i] <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : pulse
  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    {rst, strap, cap0, cap1, ev} = 13'h1000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rw(0, 8'h40, 0); `CHK("ctrl", 32'h0, q)
    for (int i = 0; i < 9; i++) begin
      rw(1, 8'h40, 32'(EN_ROW[i]) << gies_pkg::SRC_POS[i]);
      pulse(i);
      rw(0, 8'h44, 0); `CHK("flag", 32'h1 << gies_pkg::SRC_POS[i], q)
      `CHK("irq", EN_ROW[i], irq)
      rw(1, 8'h44, 32'h1 << gies_pkg::SRC_POS[i]);
      rw(0, 8'h44, 0); `CHK("clear", 32'h0, q)
    end
    rw(1, 8'h40, 32'h010f000f);
    @(posedge mclk) strap <= 1'b1;
    repeat (3) @(posedge mclk);
    pulse(0);
    rw(0, 8'h44, 0); `CHK("strap", 1'b0, irq)
    @(posedge mclk) {strap, cap0, cap1} <= 3'b011;
    repeat (4) @(posedge mclk);
    rw(1, 8'h44, 32'h300);
    rw(0, 8'h44, 0); `CHK("cap", 32'h301, q)
    host.xfer(1, 8'h44, 4'h2, 32'h1, q);
    rw(0, 8'h44, 0); `CHK("lane", 32'h301, q)
    host.xfer(1, 8'h40, 4'h1, 32'h0, q);
    rw(0, 8'h40, 0); `CHK("word", 32'h010f000f, q)
    rw(0, 8'h80, 0); `CHK("unmapped", 32'h0, q)
    // event onset and its write-1 clear meet in one cycle
    @(posedge mclk) ev[1] <= 1'b1;
    @(posedge mclk);
    rw(1, 8'h44, 32'h2);
    rw(0, 8'h44, 0); `CHK("race", 32'h303, q)
    `CHK("irq on", 1'b1, irq)
    // second reset in mid-run, source lowered so no edge follows it
    @(posedge mclk) {rst, ev[1]} <= 2'b10;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    `CHK("rst irq", 1'b0, irq)
    rw(0, 8'h40, 0); `CHK("rst ctrl", 32'h0, q)
    rw(0, 8'h44, 0); `CHK("rst stat", 32'h300, q)
    conclude();
  end
endmodule : testbench
bind gies_top gies_sva chk (.mclk(mclk), .rst(rst), .regSel(regSel),
  .regWr(regWr), .regAddr(regAddr), .regRdata(regRdata), .regAck(regAck),
  .intDisableStrap(intDisableStrap), .sysIrq(sysIrq));
